/* lpm_consts.svh */
`ifndef LPM_CONSTS_SVH
`define LPM_CONSTS_SVH

// ****************************************
// Decoded I/O addresses
// ****************************************
`define LPM_DEBUG_PORT  16'h0080
`define LPM_KBD_DATA    16'h0060
`define LPM_KBD_CMD     16'h0064
`define LPM_MOUSE_DATA  16'h0062
`define LPM_MOUSE_CMD   16'h0066
`define LPM_RTC_INDEX   16'h0070
`define LPM_RTC_DATA    16'h0071
`define LPM_LOWIO_MSB   15
`define LPM_LOWIO_LSB   11

// ****************************************
// Pin function status bit positions
// ****************************************
`define LPM_BIT_IRQ1    0
`define LPM_BIT_KEYBOARD_CTRL_SELECT_N    1
`define LPM_BIT_MOUSE_CTRL_SELECT_N    2
`define LPM_BIT_SERIALIZED_IRQ_INPUT   3
`define LPM_BIT_LED     4
`define LPM_BIT_IRQ8    5
`define LPM_BIT_RTC_SELECT_N   6
`define LPM_BIT_LOWIO   7
`define LPM_SW_SEL_MASK 8'h98
`define LPM_STATUS_RST  8'h00

// ****************************************
// ROM decoder configuration
// ****************************************
`define LPM_ROMCFG_WREN  0
`define LPM_ROMCFG_EN    1
`define LPM_ROMCFG_RMSB  3
`define LPM_ROMCFG_RLSB  2
`define LPM_BIOS_SHIFT   6'h14
`define LPM_ALL_ONES     32'hffffffff

// ****************************************
// Reset values of pin drivers
// ****************************************
`define LPM_PIN_OUT_RST  8'hef
`define LPM_PIN_OEN_RST  8'hff
`define LPM_CHAN_RST     4'h0

`endif

/* lpm_pkg.sv */
package lpm_pkg;

  // ****************************************
  // Sequencer states
  // ****************************************
  typedef enum logic [1:0] {
    LPM_ST_STRAP = 2'b00,
    LPM_ST_RUN   = 2'b01
  } lpm_state_t;

endpackage

/* lpm_addr_decode.sv */
`include "lpm_consts.svh"

module lpm_addr_decode
  import lpm_pkg::*;
(
  // ISA I/O cycle
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioRdN,
  input  wire logic        ioWrN,
  // Memory cycle
  input  wire logic [31:0] memAddr,
  input  wire logic        memRdN,
  input  wire logic        memWrN,
  // ROM decoder configuration
  input  wire logic [3:0]  romDecoderConfig,
  // Decoded hits
  output logic             debugHit,
  output logic             kbdHit,
  output logic             mouseHit,
  output logic             rtcHit,
  output logic             lowIoHit,
  output logic             romHit
);

  logic        ioCycle;
  logic [5:0]  romShift;
  logic [31:0] romMask;

  // ****************************************
  // Address comparison
  // ****************************************
  always_comb
  begin
    ioCycle  = !ioRdN || !ioWrN;
    debugHit = !ioWrN && (ioAddr == `LPM_DEBUG_PORT);
    kbdHit   = ioCycle && ((ioAddr == `LPM_KBD_DATA) || (ioAddr == `LPM_KBD_CMD));
    mouseHit = ioCycle && ((ioAddr == `LPM_MOUSE_DATA) || (ioAddr == `LPM_MOUSE_CMD));
    rtcHit   = ioCycle && ((ioAddr == `LPM_RTC_INDEX) || (ioAddr == `LPM_RTC_DATA));
    lowIoHit = ioCycle && (ioAddr[`LPM_LOWIO_MSB:`LPM_LOWIO_LSB] == 5'h00);
    romShift = `LPM_BIOS_SHIFT + {4'h0, romDecoderConfig[`LPM_ROMCFG_RMSB:`LPM_ROMCFG_RLSB]};
    romMask  = `LPM_ALL_ONES << romShift;
    // Writes reach the ROM only while BIOS write is enabled.
    romHit   = ((memAddr & romMask) == romMask)
               && (!memRdN || (!memWrN && romDecoderConfig[`LPM_ROMCFG_WREN]));
  end

endmodule

/* lpm_pin_mux.sv */
// Operation
// - Debug select asserts only on I/O writes to port 80h.
// - Shared debug pin acts as debug select by default.
// - Keyboard strap sampled in reset; low enables keyboard, mouse and IRQ1 roles.
// - ROM select decodes BIOS range when config bit or pin strap enables.
// - Pin 1 gives keyboard select for 60h and 64h when strapped.
// - Pin 2 gives mouse select for 62h and 66h when strapped.
// - Pin 6 gives RTC select for 70h and 71h when RTC strapped.
// - Pin 5 takes IRQ8 input when RTC strapped.
// - Pin 7 gives low I/O select when SA15..11 are zero and selected.
// - Pin 4 drives power LED when selected; low after reset.
// - Pin 3 forwards a parallel IRQ as a programmable serial channel.
// - Pin 0 takes IRQ1 input when keyboard strapped.
// - Each pin is plain GPIO unless its alternate role is selected.
// - Clock select defaults to 24.576 MHz; strapped low picks 25 MHz.
// - Status holds one select bit per pin; bits 3, 4, 7 software only.
`include "lpm_consts.svh"

module lpm_pin_mux
  import lpm_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst,
  // ISA cycle
  input  wire logic [15:0] ioAddr,
  input  wire logic        ioRdN,
  input  wire logic        ioWrN,
  input  wire logic [31:0] memAddr,
  input  wire logic        memRdN,
  input  wire logic        memWrN,
  // Configuration
  input  wire logic [3:0]  romDecoderConfig,
  input  wire logic [7:0]  softSelect,
  input  wire logic [3:0]  irqChannelCfg,
  input  wire logic        powerLedLevel,
  input  wire logic        rtcEnableStrapN,
  // General-purpose side
  input  wire logic [7:0]  gpioOutData,
  input  wire logic [7:0]  gpioDirIn,
  output logic      [7:0]  gpioInData,
  // Shared pins 0 to 7
  input  wire logic [7:0]  pinIn,
  output logic      [7:0]  pinOut,
  output logic      [7:0]  pinOeN,
  // Debug select and keyboard strap pin
  input  wire logic        debugPinIn,
  output logic             debugPortSelectN,
  output logic             debugPinOeN,
  // BIOS ROM select pin
  input  wire logic        romPinIn,
  output logic             biosRomSelectN,
  output logic             romPinOeN,
  // Clock select strap
  input  wire logic        clkSelPinIn,
  output logic             clkSel25M,
  // Interrupt requests toward the serializer
  output logic             irq1Req,
  output logic             irq8Req,
  output logic             serializedIrqInput,
  output logic      [3:0]  serializedIrqChannel,
  // Status
  output logic      [7:0]  pinFunctionStatus
);

  logic       debugHit;
  logic       kbdHit;
  logic       mouseHit;
  logic       rtcHit;
  logic       lowIoHit;
  logic       romHit;
  logic       romEnable;
  logic [7:0] altOut;
  logic [7:0] altDrive;

  lpm_state_t state_q,     state_d;
  logic       kbdStrapN_q, kbdStrapN_d;
  logic       rtcStrapN_q, rtcStrapN_d;
  logic       romStrap_q,  romStrap_d;
  logic       clk25_q,     clk25_d;
  logic [7:0] status_q,    status_d;
  logic [7:0] pinOut_q,    pinOut_d;
  logic [7:0] pinOeN_q,    pinOeN_d;
  logic [7:0] gpioIn_q,    gpioIn_d;
  logic       dbgOut_q,    dbgOut_d;
  logic       dbgOeN_q,    dbgOeN_d;
  logic       romOut_q,    romOut_d;
  logic       romOeN_q,    romOeN_d;
  logic       irq1_q,      irq1_d;
  logic       irq8_q,      irq8_d;
  logic       serialized_irq_input_q,     serialized_irq_input_d;
  logic [3:0] irqChan_q,   irqChan_d;

  // ****************************************
  // Address decoder
  // ****************************************
  lpm_addr_decode u_decode (
    .ioAddr           (ioAddr),
    .ioRdN            (ioRdN),
    .ioWrN            (ioWrN),
    .memAddr          (memAddr),
    .memRdN           (memRdN),
    .memWrN           (memWrN),
    .romDecoderConfig (romDecoderConfig),
    .debugHit         (debugHit),
    .kbdHit           (kbdHit),
    .mouseHit         (mouseHit),
    .rtcHit           (rtcHit),
    .lowIoHit         (lowIoHit),
    .romHit           (romHit)
  );

  // ****************************************
  // Straps and status
  // ****************************************
  always_comb
  begin
    state_d     = state_q;
    kbdStrapN_d = kbdStrapN_q;
    rtcStrapN_d = rtcStrapN_q;
    romStrap_d  = romStrap_q;
    clk25_d     = clk25_q;
    case (state_q)
      LPM_ST_STRAP:
      begin
        kbdStrapN_d = debugPinIn;
        rtcStrapN_d = rtcEnableStrapN;
        romStrap_d  = romPinIn;
        clk25_d     = !clkSelPinIn;
        state_d     = LPM_ST_RUN;
      end
      LPM_ST_RUN:
        state_d = LPM_ST_RUN;
      default:
        state_d = LPM_ST_STRAP;
    endcase
    status_d = softSelect & `LPM_SW_SEL_MASK;
    status_d[`LPM_BIT_IRQ1] = !kbdStrapN_q;
    status_d[`LPM_BIT_KEYBOARD_CTRL_SELECT_N] = !kbdStrapN_q;
    status_d[`LPM_BIT_MOUSE_CTRL_SELECT_N] = !kbdStrapN_q;
    status_d[`LPM_BIT_IRQ8]  = !rtcStrapN_q;
    status_d[`LPM_BIT_RTC_SELECT_N] = !rtcStrapN_q;
    if (rst)
    begin
      state_d     = LPM_ST_STRAP;
      kbdStrapN_d = debugPinIn;
      rtcStrapN_d = rtcEnableStrapN;
      romStrap_d  = romPinIn;
      clk25_d     = !clkSelPinIn;
      status_d    = `LPM_STATUS_RST;
    end
  end

  // ****************************************
  // Pin drivers
  // ****************************************
  always_comb
  begin
    romEnable = romDecoderConfig[`LPM_ROMCFG_EN] || romStrap_q;
    altOut                  = 8'hff;
    altDrive                = 8'h00;
    altOut[`LPM_BIT_KEYBOARD_CTRL_SELECT_N]   = !kbdHit;
    altOut[`LPM_BIT_MOUSE_CTRL_SELECT_N]   = !mouseHit;
    altOut[`LPM_BIT_LED]    = powerLedLevel;
    altOut[`LPM_BIT_RTC_SELECT_N]  = !rtcHit;
    altOut[`LPM_BIT_LOWIO]  = !lowIoHit;
    altDrive[`LPM_BIT_KEYBOARD_CTRL_SELECT_N]  = 1'b1;
    altDrive[`LPM_BIT_MOUSE_CTRL_SELECT_N]  = 1'b1;
    altDrive[`LPM_BIT_LED]   = 1'b1;
    altDrive[`LPM_BIT_RTC_SELECT_N] = 1'b1;
    altDrive[`LPM_BIT_LOWIO] = 1'b1;
    dbgOut_d  = !debugHit;
    dbgOeN_d  = (state_q != LPM_ST_RUN);
    romOut_d  = !(romHit && romEnable);
    romOeN_d  = !romEnable;
    irq1_d    = status_q[`LPM_BIT_IRQ1] && pinIn[`LPM_BIT_IRQ1];
    irq8_d    = status_q[`LPM_BIT_IRQ8] && pinIn[`LPM_BIT_IRQ8];
    serialized_irq_input_d   = status_q[`LPM_BIT_SERIALIZED_IRQ_INPUT] && pinIn[`LPM_BIT_SERIALIZED_IRQ_INPUT];
    irqChan_d = irqChannelCfg;
    gpioIn_d  = pinIn;
    if (rst)
    begin
      dbgOut_d  = 1'b1;
      dbgOeN_d  = 1'b1;
      romOut_d  = 1'b1;
      romOeN_d  = 1'b1;
      irq1_d    = 1'b0;
      irq8_d    = 1'b0;
      serialized_irq_input_d   = 1'b0;
      irqChan_d = `LPM_CHAN_RST;
      gpioIn_d  = 8'h00;
    end
  end

  // ****************************************
  // Per-pin function select
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < 8; i++)
    begin : g_pin
      always_comb
      begin
        if (rst)
        begin
          pinOut_d[i] = 1'(`LPM_PIN_OUT_RST >> i);
          pinOeN_d[i] = 1'(`LPM_PIN_OEN_RST >> i);
        end
        else if (status_q[i])
        begin
          pinOut_d[i] = altOut[i];
          pinOeN_d[i] = !altDrive[i];
        end
        else
        begin
          pinOut_d[i] = gpioOutData[i];
          pinOeN_d[i] = gpioDirIn[i];
        end
      end
    end
  endgenerate

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge mclk)
  begin
    state_q     <= state_d;
    kbdStrapN_q <= kbdStrapN_d;
    rtcStrapN_q <= rtcStrapN_d;
    romStrap_q  <= romStrap_d;
    clk25_q     <= clk25_d;
    status_q    <= status_d;
    pinOut_q    <= pinOut_d;
    pinOeN_q    <= pinOeN_d;
    gpioIn_q    <= gpioIn_d;
    dbgOut_q    <= dbgOut_d;
    dbgOeN_q    <= dbgOeN_d;
    romOut_q    <= romOut_d;
    romOeN_q    <= romOeN_d;
    irq1_q      <= irq1_d;
    irq8_q      <= irq8_d;
    serialized_irq_input_q     <= serialized_irq_input_d;
    irqChan_q   <= irqChan_d;
  end

  assign pinOut               = pinOut_q;
  assign pinOeN               = pinOeN_q;
  assign gpioInData           = gpioIn_q;
  assign debugPortSelectN     = dbgOut_q;
  assign debugPinOeN          = dbgOeN_q;
  assign biosRomSelectN       = romOut_q;
  assign romPinOeN            = romOeN_q;
  assign clkSel25M            = clk25_q;
  assign irq1Req              = irq1_q;
  assign irq8Req              = irq8_q;
  assign serializedIrqInput   = serialized_irq_input_q;
  assign serializedIrqChannel = irqChan_q;
  assign pinFunctionStatus    = status_q;

  // ****************************************
  // Checks
  // ****************************************
  property p_debug_only;
    @(posedge mclk) disable iff (rst)
    !dbgOut_q |-> $past(!ioWrN && (ioAddr == `LPM_DEBUG_PORT));
  endproperty
  a_debug_only: assert property (p_debug_only) else $error("debug select off target");

  property p_debug_drive;
    @(posedge mclk) disable iff (rst)
    (state_q == LPM_ST_RUN) |=> !dbgOeN_q;
  endproperty
  a_debug_drive: assert property (p_debug_drive) else $error("debug pin not driven");

  property p_kbd_strap;
    @(posedge mclk) disable iff (rst)
    $past(state_q == LPM_ST_RUN) |-> (status_q[2:0] == {3{!kbdStrapN_q}});
  endproperty
  a_kbd_strap: assert property (p_kbd_strap) else $error("keyboard status wrong");

  property p_rom_sel;
    @(posedge mclk) disable iff (rst)
    !romOut_q |-> $past(romHit && (romDecoderConfig[`LPM_ROMCFG_EN] || romStrap_q));
  endproperty
  a_rom_sel: assert property (p_rom_sel) else $error("rom select unexpected");

  property p_kbd_cs;
    @(posedge mclk) disable iff (rst)
    ($past(status_q[`LPM_BIT_KEYBOARD_CTRL_SELECT_N]) && $past(!rst)) |-> (pinOut_q[`LPM_BIT_KEYBOARD_CTRL_SELECT_N] == $past(!kbdHit));
  endproperty
  a_kbd_cs: assert property (p_kbd_cs) else $error("keyboard select wrong");

  property p_rtc_cs;
    @(posedge mclk) disable iff (rst)
    ($past(status_q[`LPM_BIT_RTC_SELECT_N]) && $past(!rst)) |-> (pinOut_q[`LPM_BIT_RTC_SELECT_N] == $past(!rtcHit));
  endproperty
  a_rtc_cs: assert property (p_rtc_cs) else $error("rtc select wrong");

  property p_led_reset;
    @(posedge mclk)
    rst |=> !pinOut_q[`LPM_BIT_LED];
  endproperty
  a_led_reset: assert property (p_led_reset) else $error("led not low after reset");

  property p_gpio_pass;
    @(posedge mclk) disable iff (rst)
    ($past(!status_q[0]) && $past(!rst)) |-> (pinOut_q[0] == $past(gpioOutData[0]))
      && (pinOeN_q[0] == $past(gpioDirIn[0]));
  endproperty
  a_gpio_pass: assert property (p_gpio_pass) else $error("gpio pass wrong");

  property p_clk_hold;
    @(posedge mclk) disable iff (rst)
    (state_q == LPM_ST_RUN) |=> $stable(clk25_q);
  endproperty
  a_clk_hold: assert property (p_clk_hold) else $error("clock select moved");

endmodule

/* lpm_periph_model.sv */
module lpm_periph_model (
  // Device side
  input  wire logic [7:0] pinOut,
  input  wire logic [7:0] pinOeN,
  input  wire logic       debugPortSelectN,
  input  wire logic       debugPinOeN,
  input  wire logic       biosRomSelectN,
  input  wire logic       romPinOeN,
  // Strap and interrupt sources
  input  wire logic       kbdOn,
  input  wire logic       rtcOn,
  input  wire logic       clk25On,
  input  wire logic       romOn,
  input  wire logic [2:0] irqLevel,
  // Resolved pin levels
  output logic      [7:0] pinIn,
  output logic            debugPinIn,
  output logic            romPinIn,
  output logic            clkSelPinIn,
  output logic            rtcEnableStrapN
);
  logic [7:0] farDrive;

  // Released pins sit on pull-ups; interrupt sources drive pins 0, 3 and 5.
  assign farDrive = {2'b11, irqLevel[2], 1'b1, irqLevel[1], 2'b11, irqLevel[0]};
  assign pinIn = (pinOeN & farDrive) | (~pinOeN & pinOut);
  // Strap resistors show only while the device releases the pin.
  assign debugPinIn = debugPinOeN ? ~kbdOn : debugPortSelectN;
  assign romPinIn = romPinOeN ? romOn : biosRomSelectN;
  assign clkSelPinIn = ~clk25On;
  assign rtcEnableStrapN = ~rtcOn;
endmodule

/* legacy_chip_select_pin_mux_test.sv */
module legacy_chip_select_pin_mux_test;
  timeunit 1ns;
  timeprecision 1ps;

  logic        mclk, rst, ioRdN, ioWrN, memRdN, memWrN, powerLedLevel, rtcEnableStrapN;
  logic        debugPinIn, debugPortSelectN, debugPinOeN, romPinIn, biosRomSelectN;
  logic        romPinOeN, clkSelPinIn, clkSel25M, irq1Req, irq8Req, serializedIrqInput;
  logic        kbdOn, rtcOn, clk25On, romOn;
  logic [2:0]  irqLevel;
  logic [3:0]  romDecoderConfig, irqChannelCfg, serializedIrqChannel;
  logic [7:0]  softSelect, gpioOutData, gpioDirIn, gpioInData, pinIn, pinOut, pinOeN;
  logic [7:0]  pinFunctionStatus;
  logic [15:0] ioAddr;
  logic [31:0] memAddr;
  int          errTotal, checks;

  logic [15:0] tAddr [12] = '{16'h0060, 16'h0064, 16'h0062, 16'h0066, 16'h0070, 16'h0071,
                              16'h0080, 16'h0080, 16'h07ff, 16'h0800, 16'h1080, 16'h0061};
  logic [1:0]  tCmd [12] = '{2'b01, 2'b01, 2'b10, 2'b01, 2'b10, 2'b01,
                             2'b10, 2'b01, 2'b01, 2'b10, 2'b10, 2'b01};
  logic [4:0]  tExp [12] = '{5'h16, 5'h16, 5'h1a, 5'h1a, 5'h1c, 5'h1c,
                             5'h0e, 5'h1e, 5'h1e, 5'h1f, 5'h1f, 5'h1e};

  lpm_pin_mux i_dut (
    .mclk, .rst, .ioAddr, .ioRdN, .ioWrN, .memAddr, .memRdN, .memWrN,
    .romDecoderConfig, .softSelect, .irqChannelCfg, .powerLedLevel, .rtcEnableStrapN,
    .gpioOutData, .gpioDirIn, .gpioInData, .pinIn, .pinOut, .pinOeN,
    .debugPinIn, .debugPortSelectN, .debugPinOeN, .romPinIn, .biosRomSelectN, .romPinOeN,
    .clkSelPinIn, .clkSel25M, .irq1Req, .irq8Req, .serializedIrqInput,
    .serializedIrqChannel, .pinFunctionStatus
  );

  lpm_periph_model i_periph (
    .pinOut, .pinOeN, .debugPortSelectN, .debugPinOeN, .biosRomSelectN, .romPinOeN,
    .kbdOn, .rtcOn, .clk25On, .romOn, .irqLevel,
    .pinIn, .debugPinIn, .romPinIn, .clkSelPinIn, .rtcEnableStrapN
  );

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      errTotal++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic settle();
    repeat (3) @(posedge mclk);
    #1;
  endtask

  task automatic doReset(input logic [3:0] straps);
    @(posedge mclk);
    rst <= 1'b1;
    {kbdOn, rtcOn, clk25On, romOn} <= straps;
    repeat (2) @(posedge mclk);
    #1;
    chk(pinOut, 8'hef, "pins in reset");
    chk(pinFunctionStatus, 8'h00, "status in reset");
    @(posedge mclk);
    rst <= 1'b0;
    repeat (5) @(posedge mclk);
    #1;
    chk(debugPinOeN, 1'b0, "debug pin driven");
  endtask

  task automatic decodeAll(input logic strapped);
    for (int i = 0; i < 12; i++)
    begin
      @(posedge mclk);
      ioAddr <= tAddr[i];
      {ioRdN, ioWrN} <= tCmd[i];
      settle();
      chk({debugPortSelectN, pinOut[1], pinOut[2], pinOut[6], pinOut[7]},
          strapped ? tExp[i] : {tExp[i][4], 4'hf}, "io decode");
      @(posedge mclk);
      {ioRdN, ioWrN} <= 2'b11;
      settle();
      chk({debugPortSelectN, pinOut[1], pinOut[2], pinOut[6], pinOut[7]}, 5'h1f, "io idle");
    end
  endtask

  task automatic romCase(input logic [3:0] cfg, input logic [31:0] a, input logic [1:0] cmd,
                         input logic expN);
    @(posedge mclk);
    romDecoderConfig <= cfg;
    memAddr <= a;
    {memRdN, memWrN} <= cmd;
    settle();
    chk(biosRomSelectN, expN, "rom select");
    @(posedge mclk);
    {memRdN, memWrN} <= 2'b11;
    settle();
    chk(biosRomSelectN, 1'b1, "rom idle");
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic testPlain();
    doReset(4'b0000);
    chk(pinFunctionStatus, 8'h00, "no straps");
    chk({clkSel25M, romPinOeN}, 2'b01, "clock default, rom pin released");
    @(posedge mclk);
    clk25On <= 1'b1;
    softSelect <= 8'h67;
    gpioOutData <= 8'h5a;
    gpioDirIn <= 8'h00;
    irqLevel <= 3'b111;
    settle();
    chk(clkSel25M, 1'b0, "clock frozen");
    chk(pinFunctionStatus, 8'h00, "strap bits not soft");
    chk({pinOeN, pinOut, gpioInData}, {8'h00, 8'h5a, 8'h5a}, "gpio out");
    chk({irq1Req, irq8Req, serializedIrqInput}, 3'b000, "irq gated");
    @(posedge mclk);
    gpioDirIn <= 8'hff;
    irqLevel <= 3'b000;
    settle();
    chk({pinOeN, gpioInData}, {8'hff, 8'hd6}, "gpio in");
    @(posedge mclk);
    gpioDirIn <= 8'h00;
    gpioOutData <= 8'hff;
    decodeAll(1'b0);
    romCase(4'h0, 32'hfff00000, 2'b01, 1'b1);
    romCase(4'h2, 32'hfff00000, 2'b01, 1'b0);
    romCase(4'h2, 32'hffeffff0, 2'b01, 1'b1);
    romCase(4'h2, 32'hfff00010, 2'b10, 1'b1);
    romCase(4'h3, 32'hfff00010, 2'b10, 1'b0);
    romCase(4'h6, 32'hffe00000, 2'b01, 1'b0);
    romCase(4'h6, 32'hffdffff0, 2'b01, 1'b1);
    romCase(4'ha, 32'hffc00000, 2'b01, 1'b0);
    $display("test plain done");
  endtask

  task automatic testStrapped();
    @(posedge mclk);
    softSelect <= 8'h98;
    romDecoderConfig <= 4'h0;
    powerLedLevel <= 1'b1;
    irqChannelCfg <= 4'h9;
    doReset(4'b1111);
    chk(pinFunctionStatus, 8'hff, "all roles");
    chk({clkSel25M, romPinOeN, pinOeN}, {1'b1, 1'b0, 8'h29}, "strap clock, inputs");
    chk(pinOut[4], 1'b1, "led on");
    @(posedge mclk);
    powerLedLevel <= 1'b0;
    irqLevel <= 3'b101;
    settle();
    chk({pinOut[4], irq1Req, serializedIrqInput, irq8Req, serializedIrqChannel},
        {1'b0, 1'b1, 1'b0, 1'b1, 4'h9}, "led off, irqs");
    @(posedge mclk);
    irqLevel <= 3'b010;
    settle();
    chk({irq1Req, serializedIrqInput, irq8Req}, 3'b010, "irqs swapped");
    decodeAll(1'b1);
    romCase(4'h0, 32'hfff00000, 2'b01, 1'b0);
    romCase(4'hc, 32'hff800000, 2'b01, 1'b0);
    romCase(4'hc, 32'hff7ffff0, 2'b01, 1'b1);
    $display("test strapped done");
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks, errTotal);
    if (errTotal == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial
  begin
    #50000;
    errTotal++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial
  begin
    rst = 1'b1;
    {ioRdN, ioWrN, memRdN, memWrN} = 4'hf;
    ioAddr = 16'h0000;
    memAddr = 32'h00000000;
    {romDecoderConfig, irqChannelCfg} = 8'h00;
    {softSelect, gpioOutData} = 16'h0000;
    gpioDirIn = 8'hff;
    powerLedLevel = 1'b0;
    {kbdOn, rtcOn, clk25On, romOn} = 4'h0;
    irqLevel = 3'b000;
    errTotal = 0;
    checks = 0;
    testPlain();
    testStrapped();
    summarize();
  end
endmodule
